// ---- apgq_pkg.sv ----
// Shared constants and types for the analog-port GPIO and command-queue block
package apgq_pkg;
	localparam int unsigned PORT_A_W      = 5;
	localparam int unsigned PORT_B_W      = 4;
	localparam int unsigned ENTRY_W       = 16;
	localparam int unsigned IDX_W         = 6;
	localparam int unsigned PTR_W         = 7;
	localparam int unsigned CHAN_LSB      = 0;
	localparam int unsigned CHAN_W        = 6;
	localparam logic [IDX_W-1:0]    LAST_ENTRY     = 6'h3F;
	localparam logic [CHAN_W-1:0]   END_OF_QUEUE_CODE = 6'h3F;
	localparam logic [PTR_W-1:0]    Q2_START_RESET = 7'h7F;
	localparam logic [PORT_A_W-1:0] PORT_A_RESET   = 5'h00;
	localparam logic [PORT_B_W-1:0] PORT_B_RESET   = 4'h0;
	localparam logic [IDX_W-1:0]    CMD_PTR_RESET  = 6'h00;

	typedef enum logic [3:0] {
		APGQ_IDLE    = 4'h1,
		APGQ_FETCH   = 4'h2,
		APGQ_DECODE  = 4'h4,
		APGQ_CONVERT = 4'h8
	} apgq_state_t;
endpackage

// ---- apgq_cmd_table.sv ----
// Command table memory: one write port, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module apgq_cmd_table (
	input  wire logic                          sys_clk,
	input  wire logic                          wr_en,
	input  wire logic [apgq_pkg::IDX_W-1:0]    wr_idx,
	input  wire logic [apgq_pkg::ENTRY_W-1:0]  wr_data,
	input  wire logic [apgq_pkg::IDX_W-1:0]    rd_a_idx,
	output var  logic [apgq_pkg::ENTRY_W-1:0]  rd_a_data,
	input  wire logic [apgq_pkg::IDX_W-1:0]    rd_b_idx,
	output var  logic [apgq_pkg::ENTRY_W-1:0]  rd_b_data
);
	import apgq_pkg::*;

	logic [ENTRY_W-1:0] mem [0:(1<<IDX_W)-1];

	// No reset on the array so it maps to RAM
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
		rd_a_data <= mem[rd_a_idx];
		rd_b_data <= mem[rd_b_idx];
	end
endmodule // apgq_cmd_table
`default_nettype wire

// ---- apgq_top.sv ----
// Analog port GPIO, command table and two-queue command sequencer
// Functional notes
// - Both analog ports work as digital pins with no pin-assignment register, while conversion may use them too.
// - Each pin's direction comes from its bit in the port's direction register.
// - Reading port data gives live levels on input pins and the stored drive value on output pins.
// - A pin driven as output and then converted yields the analog level of the driven value.
// - Port B's four digital bits are zero after reset.
// - The queue-2 start pointer resets to 127, and at that value a queue-2 trigger converts nothing.
// - There is no per-sample ready flag; progress shows only through each queue's command pointer.
// - Each command entry is one 16-bit word written and read by its index.
// - The channel number of an entry sits in its low six bits.
// - Queue 1 starts at entry 0 and queue 2 at its start pointer; each stops at an end-of-queue entry, queue 2 otherwise at entry 63.
// - An entry with channel 63 ends the queue, its other fields are ignored and nothing is converted.
`timescale 1ns/10ps
`default_nettype none
module apgq_top (
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	input  wire logic [apgq_pkg::PORT_A_W-1:0] pa_in,
	output var  logic [apgq_pkg::PORT_A_W-1:0] pa_out,
	output var  logic [apgq_pkg::PORT_A_W-1:0] pa_oe,
	input  wire logic [apgq_pkg::PORT_B_W-1:0] pb_in,
	output var  logic [apgq_pkg::PORT_B_W-1:0] pb_out,
	output var  logic [apgq_pkg::PORT_B_W-1:0] pb_oe,
	input  wire logic                          dir_a_wr,
	input  wire logic [apgq_pkg::PORT_A_W-1:0] dir_a_wdata,
	input  wire logic                          dir_b_wr,
	input  wire logic [apgq_pkg::PORT_B_W-1:0] dir_b_wdata,
	input  wire logic                          data_a_wr,
	input  wire logic [apgq_pkg::PORT_A_W-1:0] data_a_wdata,
	input  wire logic                          data_b_wr,
	input  wire logic [apgq_pkg::PORT_B_W-1:0] data_b_wdata,
	output var  logic [apgq_pkg::PORT_A_W-1:0] port_a_rdata,
	output var  logic [apgq_pkg::PORT_B_W-1:0] port_b_rdata,
	input  wire logic                          cmd_wr,
	input  wire logic [apgq_pkg::IDX_W-1:0]    cmd_idx,
	input  wire logic [apgq_pkg::ENTRY_W-1:0]  cmd_wdata,
	output var  logic [apgq_pkg::ENTRY_W-1:0]  cmd_rdata,
	input  wire logic                          q2_start_wr,
	input  wire logic [apgq_pkg::PTR_W-1:0]    q2_start_wdata,
	output var  logic [apgq_pkg::PTR_W-1:0]    queue2_start_pointer,
	input  wire logic                          q1_trig,
	input  wire logic                          q2_trig,
	output var  logic                          conv_start,
	output var  logic [apgq_pkg::CHAN_W-1:0]   conv_channel,
	output var  logic [apgq_pkg::IDX_W-1:0]    conv_idx,
	input  wire logic                          conv_done,
	output var  logic                          queue_busy,
	output var  logic [apgq_pkg::IDX_W-1:0]    queue1_command_pointer,
	output var  logic [apgq_pkg::IDX_W-1:0]    queue2_command_pointer
);
	import apgq_pkg::*;

	typedef struct packed {
		logic [PORT_A_W-1:0] pa_s1;
		logic [PORT_A_W-1:0] pa_s2;
		logic [PORT_B_W-1:0] pb_s1;
		logic [PORT_B_W-1:0] pb_s2;
		logic [PORT_A_W-1:0] dir_a;
		logic [PORT_B_W-1:0] dir_b;
		logic [PORT_A_W-1:0] data_a;
		logic [PORT_B_W-1:0] data_b;
		logic [PORT_A_W-1:0] read_a;
		logic [PORT_B_W-1:0] read_b;
		logic [PTR_W-1:0]    q2_start;
		logic [IDX_W-1:0]    q1_ptr;
		logic [IDX_W-1:0]    q2_ptr;
		apgq_state_t         state;
		logic [IDX_W-1:0]    idx;
		logic [IDX_W-1:0]    last;
		logic                on_q2;
		logic                q1_pend;
		logic                q2_pend;
		logic                start;
		logic [CHAN_W-1:0]   chan;
	} apgq_regs_t;

	apgq_regs_t          cur;
	apgq_regs_t          next_cur;
	logic [ENTRY_W-1:0]  eng_rdata;
	logic [CHAN_W-1:0]   eng_chan;

	// Read data for output pins reflects the stored value, input pins the synchronised level
	function automatic logic [PORT_A_W-1:0] pin_view(input logic [PORT_A_W-1:0] dir,
			input logic [PORT_A_W-1:0] data, input logic [PORT_A_W-1:0] live);
		pin_view = (dir & data) | (~dir & live);
	endfunction

	function automatic logic q2_enabled(input logic [PTR_W-1:0] start);
		q2_enabled = (start <= {1'b0, LAST_ENTRY});
	endfunction

	apgq_cmd_table apgq_cmd_table_i (
		.sys_clk   (sys_clk),
		.wr_en     (cmd_wr),
		.wr_idx    (cmd_idx),
		.wr_data   (cmd_wdata),
		.rd_a_idx  (cmd_idx),
		.rd_a_data (cmd_rdata),
		.rd_b_idx  (cur.idx),
		.rd_b_data (eng_rdata)
	);

	assign eng_chan = eng_rdata[CHAN_LSB +: CHAN_W];

	always_comb begin
		next_cur       = cur;
		next_cur.start = 1'b0;
		next_cur.pa_s1 = pa_in;
		next_cur.pa_s2 = cur.pa_s1;
		next_cur.pb_s1 = pb_in;
		next_cur.pb_s2 = cur.pb_s1;
		if (dir_a_wr) begin
			next_cur.dir_a = dir_a_wdata;
		end
		if (dir_b_wr) begin
			next_cur.dir_b = dir_b_wdata;
		end
		if (data_a_wr) begin
			next_cur.data_a = data_a_wdata;
		end
		if (data_b_wr) begin
			next_cur.data_b = data_b_wdata;
		end
		next_cur.read_a = pin_view(next_cur.dir_a, next_cur.data_a, cur.pa_s2);
		next_cur.read_b = PORT_B_W'(pin_view({1'b0, next_cur.dir_b}, {1'b0, next_cur.data_b},
			{1'b0, cur.pb_s2}));
		if (q2_start_wr) begin
			next_cur.q2_start = q2_start_wdata;
		end
		// Triggers are held until the sequencer takes them
		if (q1_trig) begin
			next_cur.q1_pend = 1'b1;
		end
		if (q2_trig) begin
			next_cur.q2_pend = 1'b1;
		end
		case (cur.state)
			APGQ_IDLE: begin
				if (cur.q1_pend || q1_trig) begin
					// A fresh trigger on the taking edge stays pending, so set wins
					next_cur.q1_pend = cur.q1_pend && q1_trig;
					next_cur.on_q2   = 1'b0;
					next_cur.idx     = '0;
					// Queue 1 stops one entry before an enabled queue 2, else at entry 63, when no end marker comes first
					if (q2_enabled(cur.q2_start) && cur.q2_start != '0) begin
						next_cur.last  = IDX_W'(cur.q2_start - 7'h01);
						next_cur.state = APGQ_FETCH;
					end else if (!q2_enabled(cur.q2_start)) begin
						next_cur.last  = LAST_ENTRY;
						next_cur.state = APGQ_FETCH;
					end
				end else if (cur.q2_pend || q2_trig) begin
					next_cur.q2_pend = cur.q2_pend && q2_trig;
					next_cur.on_q2   = 1'b1;
					next_cur.idx     = IDX_W'(cur.q2_start);
					next_cur.last    = LAST_ENTRY;
					if (q2_enabled(cur.q2_start)) begin
						next_cur.state = APGQ_FETCH;
					end
				end
			end
			APGQ_FETCH: begin
				next_cur.state = APGQ_DECODE;
			end
			APGQ_DECODE: begin
				if (eng_chan == END_OF_QUEUE_CODE) begin
					next_cur.state = APGQ_IDLE;
				end else begin
					next_cur.start = 1'b1;
					next_cur.chan  = eng_chan;
					next_cur.state = APGQ_CONVERT;
				end
			end
			APGQ_CONVERT: begin
				if (conv_done) begin
					// Pointer is the only progress report software gets
					if (cur.on_q2) begin
						next_cur.q2_ptr = cur.idx;
					end else begin
						next_cur.q1_ptr = cur.idx;
					end
					if (cur.idx == cur.last) begin
						next_cur.state = APGQ_IDLE;
					end else begin
						next_cur.idx   = cur.idx + 6'h01;
						next_cur.state = APGQ_FETCH;
					end
				end
			end
			default: begin
				next_cur.state = APGQ_IDLE;
			end
		endcase
		if (rst) begin
			next_cur          = '0;
			next_cur.dir_a    = PORT_A_RESET;
			next_cur.dir_b    = PORT_B_RESET;
			next_cur.data_a   = PORT_A_RESET;
			next_cur.data_b   = PORT_B_RESET;
			next_cur.q2_start = Q2_START_RESET;
			next_cur.q1_ptr   = CMD_PTR_RESET;
			next_cur.q2_ptr   = CMD_PTR_RESET;
			next_cur.state    = APGQ_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		cur <= next_cur;
	end

	// Driven value stays on the pin during conversion, so the converter sees it
	assign pa_out                 = cur.data_a;
	assign pa_oe                  = cur.dir_a;
	assign pb_out                 = cur.data_b;
	assign pb_oe                  = cur.dir_b;
	assign port_a_rdata           = cur.read_a;
	assign port_b_rdata           = cur.read_b;
	assign queue2_start_pointer   = cur.q2_start;
	assign conv_start             = cur.start;
	assign conv_channel           = cur.chan;
	assign conv_idx               = cur.idx;
	assign queue_busy             = (cur.state != APGQ_IDLE);
	assign queue1_command_pointer = cur.q1_ptr;
	assign queue2_command_pointer = cur.q2_ptr;

	chk_dir_write: assert property (@(posedge sys_clk) disable iff (rst)
		dir_a_wr |=> pa_oe == $past(dir_a_wdata))
		else $error("port A direction not taken from register write");

	chk_read_output: assert property (@(posedge sys_clk) disable iff (rst)
		((port_a_rdata ^ pa_out) & pa_oe) == '0)
		else $error("output pin read differs from driven value");

	chk_portb_reset: assert property (@(posedge sys_clk)
		rst |=> (pb_out == PORT_B_RESET) && (pb_oe == PORT_B_RESET))
		else $error("port B not zero after reset");

	chk_q2_reset: assert property (@(posedge sys_clk)
		rst |=> queue2_start_pointer == Q2_START_RESET)
		else $error("queue 2 start pointer reset value wrong");

	chk_q2_null: assert property (@(posedge sys_clk) disable iff (rst)
		(conv_start && cur.on_q2) |-> queue2_start_pointer != Q2_START_RESET)
		else $error("conversion started with queue 2 disabled");

	chk_eoq_skip: assert property (@(posedge sys_clk) disable iff (rst)
		conv_start |-> conv_channel != END_OF_QUEUE_CODE)
		else $error("end-of-queue entry was converted");

	chk_q2_bound: assert property (@(posedge sys_clk) disable iff (rst)
		(conv_start && cur.on_q2) |-> {1'b0, conv_idx} >= queue2_start_pointer)
		else $error("queue 2 converted below its start");

	chk_q1_bound: assert property (@(posedge sys_clk) disable iff (rst)
		(conv_start && !cur.on_q2 && queue2_start_pointer <= 7'h3F) |->
		{1'b0, conv_idx} < queue2_start_pointer)
		else $error("queue 1 ran into queue 2");

	chk_ptr_update: assert property (@(posedge sys_clk) disable iff (rst)
		(cur.state == APGQ_CONVERT && conv_done && !cur.on_q2 && !q2_start_wr) |=>
		queue1_command_pointer == $past(conv_idx))
		else $error("queue 1 pointer not updated on completion");

	chk_start_gap: assert property (@(posedge sys_clk) disable iff (rst)
		conv_start |=> !conv_start [*2])
		else $error("conversion starts too close together");
endmodule // apgq_top
`default_nettype wire

// ---- tb_apgq_top.sv ----
// Self-checking bench for the analog-port GPIO and command-queue block
`timescale 1ns/10ps
`default_nettype none
module tb_apgq_top;
	import apgq_pkg::*;
	logic                sys_clk = 1'b0;
	logic                rst = 1'b1;
	logic [PORT_A_W-1:0] pa_in = '0, pa_out, pa_oe, dir_a_wdata = '0, data_a_wdata = '0, port_a_rdata;
	logic [PORT_B_W-1:0] pb_in = '0, pb_out, pb_oe, dir_b_wdata = '0, data_b_wdata = '0, port_b_rdata;
	logic                dir_a_wr = 1'b0, dir_b_wr = 1'b0, data_a_wr = 1'b0, data_b_wr = 1'b0;
	logic                cmd_wr = 1'b0, q2_start_wr = 1'b0, q1_trig = 1'b0, q2_trig = 1'b0;
	logic                conv_done = 1'b0, conv_start, queue_busy;
	logic [IDX_W-1:0]    cmd_idx = '0, conv_idx, queue1_command_pointer, queue2_command_pointer;
	logic [ENTRY_W-1:0]  cmd_wdata = '0, cmd_rdata;
	logic [PTR_W-1:0]    q2_start_wdata = '0, queue2_start_pointer;
	logic [CHAN_W-1:0]   conv_channel;
	int                  n_errors = 0;
	int                  check_count = 0;

	apgq_top apgq_top_i (.sys_clk(sys_clk), .rst(rst), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .dir_a_wr(dir_a_wr), .dir_a_wdata(dir_a_wdata),
		.dir_b_wr(dir_b_wr), .dir_b_wdata(dir_b_wdata), .data_a_wr(data_a_wr), .data_a_wdata(data_a_wdata),
		.data_b_wr(data_b_wr), .data_b_wdata(data_b_wdata), .port_a_rdata(port_a_rdata),
		.port_b_rdata(port_b_rdata), .cmd_wr(cmd_wr), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .q2_start_wr(q2_start_wr), .q2_start_wdata(q2_start_wdata),
		.queue2_start_pointer(queue2_start_pointer), .q1_trig(q1_trig), .q2_trig(q2_trig),
		.conv_start(conv_start), .conv_channel(conv_channel), .conv_idx(conv_idx), .conv_done(conv_done),
		.queue_busy(queue_busy), .queue1_command_pointer(queue1_command_pointer),
		.queue2_command_pointer(queue2_command_pointer));

	always #5 sys_clk = ~sys_clk;

	task automatic test_done();
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_cmd(input logic [IDX_W-1:0] idx, input logic [ENTRY_W-1:0] word);
		@(negedge sys_clk) cmd_wr = 1'b1;
		cmd_idx = idx;
		cmd_wdata = word;
		@(negedge sys_clk) cmd_wr = 1'b0;
	endtask

	// Converter stand-in: answers one cycle after the start pulse has passed
	task automatic serve_conv(input logic [CHAN_W-1:0] ch, input logic [IDX_W-1:0] idx);
		int n;
		n = 0;
		while (conv_start !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk("conv_start", 16'h0001, conv_start);
		chk("queue_busy", 16'h0001, queue_busy);
		chk("conv_channel", ch, conv_channel);
		chk("conv_idx", idx, conv_idx);
		@(negedge sys_clk) conv_done = 1'b1;
		@(negedge sys_clk) conv_done = 1'b0;
	endtask

	// Stray start pulses within the window mean a marker or empty queue was converted
	task automatic expect_idle(input string what);
		int starts;
		starts = 0;
		repeat (12) @(negedge sys_clk) starts += int'(conv_start === 1'b1);
		chk(what, 16'h0000, 16'(starts));
		chk("queue_busy", 16'h0000, queue_busy);
	endtask

	task automatic t_reset();
		chk("pb_out", 16'h0000, pb_out);
		chk("pb_oe", 16'h0000, pb_oe);
		chk("pa_oe", 16'h0000, pa_oe);
		chk("queue2_start_pointer", 16'h007F, queue2_start_pointer);
		chk("queue1_command_pointer", 16'h0000, queue1_command_pointer);
	endtask

	task automatic t_ports();
		pa_in = 5'h0A;
		pb_in = 4'hA;
		@(negedge sys_clk) dir_a_wr = 1'b1;
		dir_a_wdata = 5'h11;
		data_a_wr = 1'b1;
		data_a_wdata = 5'h1F;
		dir_b_wr = 1'b1;
		dir_b_wdata = 4'hF;
		data_b_wr = 1'b1;
		data_b_wdata = 4'h5;
		@(negedge sys_clk) {dir_a_wr, data_a_wr, dir_b_wr, data_b_wr} = 4'h0;
		repeat (4) @(negedge sys_clk);
		chk("pa_oe", 16'h0011, pa_oe);
		chk("pa_out", 16'h001F, pa_out);
		chk("port_a_rdata", 16'h001B, port_a_rdata);
		chk("pb_oe", 16'h000F, pb_oe);
		chk("pb_out", 16'h0005, pb_out);
		chk("port_b_rdata", 16'h0005, port_b_rdata);
	endtask

	task automatic t_table();
		wr_cmd(6'h0A, 16'hABCD);
		@(negedge sys_clk);
		chk("cmd_rdata", 16'hABCD, cmd_rdata);
		wr_cmd(6'h00, 16'hFFC5);
		wr_cmd(6'h01, 16'h12FF);
		wr_cmd(6'h02, 16'h0009);
		wr_cmd(6'h03, 16'hFFFF);
		cmd_idx = 6'h00;
		@(negedge sys_clk);
		chk("cmd_rdata", 16'hFFC5, cmd_rdata);
	endtask

	task automatic t_q2_parked();
		@(negedge sys_clk) q2_trig = 1'b1;
		@(negedge sys_clk) q2_trig = 1'b0;
		expect_idle("q2 starts while parked");
	endtask

	task automatic t_both_queues();
		@(negedge sys_clk) q2_start_wr = 1'b1;
		q2_start_wdata = 7'h02;
		@(negedge sys_clk) q2_start_wr = 1'b0;
		chk("queue2_start_pointer", 16'h0002, queue2_start_pointer);
		q1_trig = 1'b1;
		q2_trig = 1'b1;
		@(negedge sys_clk) {q1_trig, q2_trig} = 2'h0;
		serve_conv(6'h05, 6'h00);
		chk("pa_out", 16'h001F, pa_out);
		serve_conv(6'h09, 6'h02);
		expect_idle("starts after markers");
		chk("queue1_command_pointer", 16'h0000, queue1_command_pointer);
		chk("queue2_command_pointer", 16'h0002, queue2_command_pointer);
		chk("pa_oe", 16'h0011, pa_oe);
	endtask

	// Reset in mid-run must clear port B drive and park queue 2 again
	task automatic t_reset_again();
		@(negedge sys_clk) rst = 1'b1;
		@(negedge sys_clk) rst = 1'b0;
		chk("pb_out", 16'h0000, pb_out);
		chk("pb_oe", 16'h0000, pb_oe);
		chk("queue2_start_pointer", 16'h007F, queue2_start_pointer);
		chk("queue2_command_pointer", 16'h0000, queue2_command_pointer);
		repeat (4) @(negedge sys_clk);
		chk("port_b_rdata", 16'h000A, port_b_rdata);
		chk("port_a_rdata", 16'h000A, port_a_rdata);
		t_q2_parked();
	endtask

	initial begin
		#50000;
		n_errors++;
		test_done();
	end

	initial begin
		repeat (8) @(negedge sys_clk);
		t_reset();
		rst = 1'b0;
		t_ports();
		t_table();
		t_q2_parked();
		t_both_queues();
		t_reset_again();
		test_done();
	end
endmodule // tb_apgq_top
`default_nettype wire
